//--- sefh_defs.vh
// Constants for the stepper encoder feedback and homing block
`ifndef SEFH_DEFS_VH
`define SEFH_DEFS_VH
`define SEFH_A_CTRL      8'h00
`define SEFH_A_CFG       8'h04
`define SEFH_A_CMD       8'h08
`define SEFH_A_PRESET    8'h0C
`define SEFH_A_STATUS    8'h10
`define SEFH_A_MPOS      8'h14
`define SEFH_A_EPOS      8'h18
`define SEFH_A_PERR      8'h1C
`define SEFH_A_CURR      8'h20
`define SEFH_A_CPR       8'h24
// CTRL fields
`define SEFH_C_ENC_EN    0
`define SEFH_C_STALL_EN  1
`define SEFH_C_HYB_EN    2
`define SEFH_C_GEARING   3
`define SEFH_C_EARLY_REV 4
// CFG fields
`define SEFH_F_IDLE_LSB  0
`define SEFH_F_GAIN_LSB  8
`define SEFH_F_RUN_LSB   16
`define SEFH_F_HGAIN_LSB 24
// CMD codes in bits 2:0; bit 3 carries hybrid enable, applied only when bit 4 is set
`define SEFH_CMD_NONE    3'h0
`define SEFH_CMD_REL     3'h1
`define SEFH_CMD_ABS     3'h2
`define SEFH_CMD_HOME_P  3'h3
`define SEFH_CMD_HOME_N  3'h4
`define SEFH_CMD_STOP    3'h5
`define SEFH_CMD_PRE_M   3'h6
`define SEFH_CMD_PRE_E   3'h7
`define SEFH_CMD_HYB_BIT 3
`define SEFH_CMD_HYB_UPD 4
// STATUS bits
`define SEFH_S_BUSY      0
`define SEFH_S_HOMED     1
`define SEFH_S_STALL     2
`define SEFH_S_LAG       3
`define SEFH_S_CFG_ERR   4
`define SEFH_S_CMD_ERR   5
`define SEFH_S_DIR       6
// Reset values
`define SEFH_RST_CFG     32'h1005_6419
`define SEFH_RST_CPR     16'h1000
// Limits
`define SEFH_GAIN_MIN    7'd1
`define SEFH_GAIN_MAX    7'd80
`define SEFH_GAIN_EARLY  7'd40
`define SEFH_PCT_MAX     7'd100
`define SEFH_STEP_FAST   16'd250
`define SEFH_STEP_SLOW   16'd2500
`define SEFH_STALL_TICKS 16'd40000
`define SEFH_UPD_TICKS   16'd125
`endif

//--- sefh_quad.v
// X4 quadrature decoder with signed 24-bit position counter
`timescale 1ns/1ns
module sefh_quad #(
    parameter W = 24
) (
    input  wire         clk,
    input  wire         rst,
    input  wire         ce,
    input  wire         enc_a,
    input  wire         enc_b,
    input  wire         clr,
    input  wire         load,
    input  wire [W-1:0] load_val,
    output reg  [W-1:0] pos,
    output reg          moved
);
    reg  [1:0] ab_r;
    wire [1:0] ab = {enc_a, enc_b};
    // Gray order 00,01,11,10 forward; Z is deliberately not an input here
    wire fwd = (ab_r == 2'b00 && ab == 2'b01) || (ab_r == 2'b01 && ab == 2'b11) ||
               (ab_r == 2'b11 && ab == 2'b10) || (ab_r == 2'b10 && ab == 2'b00);
    wire rev = (ab_r == 2'b00 && ab == 2'b10) || (ab_r == 2'b10 && ab == 2'b11) ||
               (ab_r == 2'b11 && ab == 2'b01) || (ab_r == 2'b01 && ab == 2'b00);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ab_r  <= 2'b00;
            pos   <= {W{1'b0}};
            moved <= 1'b0;
        end else if (ce) begin
            ab_r  <= ab;
            moved <= fwd | rev;
            if (clr)
                pos <= {W{1'b0}};
            else if (load)
                pos <= load_val;
            else if (fwd)
                pos <= pos + {{(W-1){1'b0}}, 1'b1};
            else if (rev)
                pos <= pos - {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule

//--- sefh_top.v
// Encoder feedback, stall detection, hybrid current and homing core with APB
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "sefh_defs.vh"
module sefh_top #(
    parameter PW = 24
) (
    input  wire          CLK_SYS,
    input  wire          RST,
    input  wire          CE,
    input  wire          PSEL,
    input  wire          PENABLE,
    input  wire          PWRITE,
    input  wire [7:0]    PADDR,
    input  wire [31:0]   PWDATA,
    output reg  [31:0]   PRDATA,
    output reg           PREADY,
    output reg           PSLVERR,
    input  wire          ENC_A,
    input  wire          ENC_B,
    input  wire          ENC_Z,
    input  wire          HOME_IN,
    output reg           STEP_OUT,
    output reg           DIR_CW,
    output reg  [7:0]    CURRENT_PEAK,
    output reg           CURRENT_IDLE
);
    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    reg  [4:0]    ctrl_r;
    reg  [31:0]   cfg_r;
    reg  [PW-1:0] preset_r;
    reg  [PW-1:0] target_r;
    reg  [15:0]   cpr_r;
    reg  [6:0]    st_r;
    reg  [PW-1:0] mpos_r;
    reg  [1:0]    state_r;
    reg           hyb_r;
    reg  [15:0]   div_r;
    reg  [15:0]   stall_cnt_r;
    reg  [15:0]   upd_cnt_r;
    reg  [7:0]    cur_r;
    reg           slow_r;
    reg  [PW-1:0] perr_r;
    reg           home_q_r;

    localparam ST_IDLE = 2'd0;
    localparam ST_MOVE = 2'd1;
    localparam ST_HOME = 2'd2;

    wire          acc   = PSEL & PENABLE & PREADY;
    wire          wr    = acc & PWRITE;
    wire [2:0]    opc   = PWDATA[2:0];
    wire          cmd_w = wr && PADDR == `SEFH_A_CMD;
    wire [6:0]    idle_pct = cfg_r[`SEFH_F_IDLE_LSB +: 7];
    wire [6:0]    gain  = cfg_r[`SEFH_F_GAIN_LSB +: 7];
    wire [7:0]    run_i = cfg_r[`SEFH_F_RUN_LSB +: 8];
    wire [7:0]    hgain = cfg_r[`SEFH_F_HGAIN_LSB +: 8];
    wire [PW-1:0] epos;
    wire          enc_moved;
    wire          moving = state_r != ST_IDLE;
    // Only a fresh sensor edge at low rate ends the search, not the one that slowed it
    wire          home_done = state_r == ST_HOME && slow_r && HOME_IN && !home_q_r;

    // Preset value must fit a signed 24-bit range; wider words are refused
    wire [7:0]    pw_hi = PWDATA[31:24];
    wire          pw_ok = (pw_hi == 8'h00 && !PWDATA[23]) ||
                          (pw_hi == 8'hFF && PWDATA[23]);

    // Gain window 1..80, and early hardware stops at 40
    wire gain_bad = gain < `SEFH_GAIN_MIN || gain > `SEFH_GAIN_MAX ||
                    (ctrl_r[`SEFH_C_EARLY_REV] && gain > `SEFH_GAIN_EARLY);
    wire idle_bad = idle_pct > `SEFH_PCT_MAX;

    // Commanded minus encoder when clockwise, encoder minus commanded otherwise (cpr equals steps/turn)
    wire [PW-1:0] err_raw = DIR_CW ? mpos_r - epos : epos - mpos_r;
    wire          err_pos = !err_raw[PW-1];
    wire [PW-1:0] eighth  = {{(PW-16){1'b0}}, 3'b000, cpr_r[15:3]};
    wire [PW-1:0] full    = {{(PW-16){1'b0}}, cpr_r};
    wire          lag45   = err_pos && err_raw > eighth;
    wire          lag360  = err_pos && err_raw > full;

    sefh_quad #(
        .W (PW)
    ) u_quad (
        .clk      (CLK_SYS),
        .rst      (RST),
        .ce       (CE),
        .enc_a    (ENC_A),
        .enc_b    (ENC_B),
        .clr      (home_done && ctrl_r[`SEFH_C_ENC_EN]),
        .load     (cmd_w && opc == `SEFH_CMD_PRE_E && !moving),
        .load_val (preset_r),
        .pos      (epos),
        .moved    (enc_moved)
    );

    // -----------------------------------------------------------------
    // APB slave, one wait-free access phase
    // -----------------------------------------------------------------
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            PREADY   <= 1'b0;
            PSLVERR  <= 1'b0;
            PRDATA   <= 32'h0000_0000;
            ctrl_r   <= 5'h00;
            cfg_r    <= `SEFH_RST_CFG;
            preset_r <= {PW{1'b0}};
            cpr_r    <= `SEFH_RST_CPR;
        end else if (CE) begin
            PREADY  <= PSEL & ~PENABLE;
            PSLVERR <= 1'b0;
            if (PSEL & ~PENABLE) begin
                PSLVERR <= PADDR > `SEFH_A_CPR || PADDR[1:0] != 2'b00 ||
                           (PWRITE && PADDR == `SEFH_A_PRESET && !pw_ok);
                case (PADDR)
                    `SEFH_A_CTRL:   PRDATA <= {27'h0, ctrl_r};
                    `SEFH_A_CFG:    PRDATA <= cfg_r;
                    `SEFH_A_PRESET: PRDATA <= {{(32-PW){preset_r[PW-1]}}, preset_r};
                    `SEFH_A_STATUS: PRDATA <= {25'h0, st_r};
                    `SEFH_A_MPOS:   PRDATA <= {{(32-PW){mpos_r[PW-1]}}, mpos_r};
                    `SEFH_A_EPOS:   PRDATA <= {{(32-PW){epos[PW-1]}}, epos};
                    `SEFH_A_PERR:   PRDATA <= {{(32-PW){perr_r[PW-1]}}, perr_r};
                    `SEFH_A_CURR:   PRDATA <= {24'h0, cur_r};
                    `SEFH_A_CPR:    PRDATA <= {16'h0, cpr_r};
                    default:        PRDATA <= 32'h0000_0000;
                endcase
            end
            if (wr) begin
                case (PADDR)
                    `SEFH_A_CTRL:   ctrl_r <= PWDATA[4:0];
                    `SEFH_A_CFG:    cfg_r  <= PWDATA;
                    `SEFH_A_PRESET: if (pw_ok) preset_r <= PWDATA[PW-1:0];
                    `SEFH_A_CPR:    cpr_r  <= PWDATA[15:0];
                    default:        ;
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // Motion sequencer
    // -----------------------------------------------------------------
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_r     <= ST_IDLE;
            st_r        <= 7'h00;
            mpos_r      <= {PW{1'b0}};
            target_r    <= {PW{1'b0}};
            hyb_r       <= 1'b0;
            div_r       <= 16'h0000;
            stall_cnt_r <= 16'h0000;
            slow_r      <= 1'b0;
            home_q_r    <= 1'b0;
            STEP_OUT    <= 1'b0;
            DIR_CW      <= 1'b1;
        end else if (CE) begin
            STEP_OUT <= 1'b0;
            home_q_r <= HOME_IN;
            st_r[`SEFH_S_CFG_ERR] <= gain_bad | idle_bad;
            // Hybrid enable may be changed on the fly, or inside a start command
            if (wr && PADDR == `SEFH_A_CTRL)
                hyb_r <= PWDATA[`SEFH_C_HYB_EN];
            if (cmd_w && PWDATA[`SEFH_CMD_HYB_UPD])
                hyb_r <= PWDATA[`SEFH_CMD_HYB_BIT];
            // Stall error and lag are cleared by a new command; a same-cycle trip wins
            if (cmd_w) begin
                st_r[`SEFH_S_STALL]   <= 1'b0;
                st_r[`SEFH_S_LAG]     <= 1'b0;
                st_r[`SEFH_S_CMD_ERR] <= 1'b0;
            end
            case (state_r)
                ST_IDLE: begin
                    stall_cnt_r <= 16'h0000;
                    if (cmd_w) begin
                        case (opc)
                            `SEFH_CMD_REL: begin
                                target_r <= mpos_r + preset_r;
                                DIR_CW   <= !preset_r[PW-1];
                                state_r  <= ST_MOVE;
                            end
                            `SEFH_CMD_ABS: begin
                                // Absolute needs a defined home
                                if (st_r[`SEFH_S_HOMED]) begin
                                    target_r <= preset_r;
                                    DIR_CW   <= $signed(preset_r) >= $signed(mpos_r);
                                    state_r  <= ST_MOVE;
                                end else begin
                                    st_r[`SEFH_S_CMD_ERR] <= 1'b1;
                                end
                            end
                            `SEFH_CMD_HOME_P, `SEFH_CMD_HOME_N: begin
                                DIR_CW  <= opc == `SEFH_CMD_HOME_P;
                                slow_r  <= 1'b0;
                                state_r <= ST_HOME;
                            end
                            `SEFH_CMD_PRE_M: begin
                                mpos_r <= preset_r;
                                st_r[`SEFH_S_HOMED] <= 1'b1;
                            end
                            default: ;
                        endcase
                    end
                end
                ST_MOVE, ST_HOME: begin
                    if (div_r == 16'h0000) begin
                        div_r <= slow_r || state_r == ST_MOVE ?
                                 `SEFH_STEP_SLOW : `SEFH_STEP_FAST;
                        if (state_r == ST_MOVE && mpos_r == target_r) begin
                            state_r <= ST_IDLE;
                        end else begin
                            STEP_OUT <= 1'b1;
                            mpos_r   <= DIR_CW ? mpos_r + {{(PW-1){1'b0}}, 1'b1}
                                               : mpos_r - {{(PW-1){1'b0}}, 1'b1};
                        end
                    end else begin
                        div_r <= div_r - 16'h0001;
                    end
                    // Home first seen at speed: fall to low rate and finish there
                    if (state_r == ST_HOME && HOME_IN && !slow_r)
                        slow_r <= 1'b1;
                    if (home_done) begin
                        mpos_r  <= {PW{1'b0}};
                        st_r[`SEFH_S_HOMED] <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                    // Encoder silence watchdog during motion
                    if (enc_moved || !ctrl_r[`SEFH_C_STALL_EN])
                        stall_cnt_r <= 16'h0000;
                    else if (stall_cnt_r != `SEFH_STALL_TICKS)
                        stall_cnt_r <= stall_cnt_r + 16'h0001;
                    if (ctrl_r[`SEFH_C_STALL_EN] && !ctrl_r[`SEFH_C_GEARING] &&
                        (stall_cnt_r == `SEFH_STALL_TICKS || (hyb_r && lag45))) begin
                        st_r[`SEFH_S_STALL] <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                    // Lag flag only without stall detection; move keeps running
                    if (hyb_r && lag360 && !ctrl_r[`SEFH_C_STALL_EN])
                        st_r[`SEFH_S_LAG] <= 1'b1;
                    if (cmd_w && opc == `SEFH_CMD_STOP)
                        state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
            st_r[`SEFH_S_BUSY] <= moving;
            st_r[`SEFH_S_DIR]  <= DIR_CW;
        end
    end

    // -----------------------------------------------------------------
    // Current control
    // -----------------------------------------------------------------
    // Idle uses a "to" fraction of running current, reported as peak
    wire [14:0] idle_prod = {7'h00, run_i} * {8'h00, idle_pct};
    wire [14:0] idle_quo  = idle_prod / 15'h0064;
    wire [7:0]  idle_i    = idle_quo[7:0];
    // Correction step is hybrid gain times stiffness gain, capped at 255
    wire [15:0] step_mul  = {8'h00, hgain} * {9'h000, gain};
    wire [7:0]  corr      = |step_mul[15:8] ? 8'hFF : step_mul[7:0];

    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            upd_cnt_r    <= 16'h0000;
            cur_r        <= 8'h00;
            perr_r       <= {PW{1'b0}};
            CURRENT_PEAK <= 8'h00;
            CURRENT_IDLE <= 1'b1;
        end else if (CE) begin
            upd_cnt_r <= upd_cnt_r == `SEFH_UPD_TICKS ? 16'h0000 : upd_cnt_r + 16'h0001;
            if (upd_cnt_r == `SEFH_UPD_TICKS) begin
                perr_r <= err_raw;
                if (!moving) begin
                    cur_r <= idle_i;
                end else if (!hyb_r) begin
                    cur_r <= run_i;
                end else if (err_pos && err_raw != {PW{1'b0}}) begin
                    // Lagging: push current up, capped at running level
                    cur_r <= ({1'b0, cur_r} + {1'b0, corr} > {1'b0, run_i}) ?
                             run_i : cur_r + corr;
                end else begin
                    // Keeping up: ease down toward the least that still moves
                    cur_r <= cur_r > corr ? cur_r - corr : 8'h01;
                end
            end
            CURRENT_PEAK <= cur_r;
            CURRENT_IDLE <= !moving;
        end
    end
endmodule

//--- sefh_chk.sv
// Port-level assertions for the encoder feedback and homing block
`timescale 1ns/1ns
module sefh_chk #(
    parameter PW = 24
) (
    input wire        CLK_SYS,
    input wire        RST,
    input wire        CE,
    input wire        PSEL,
    input wire        PENABLE,
    input wire        PWRITE,
    input wire [7:0]  PADDR,
    input wire [31:0] PWDATA,
    input wire [31:0] PRDATA,
    input wire        PREADY,
    input wire        PSLVERR,
    input wire        ENC_A,
    input wire        ENC_B,
    input wire        ENC_Z,
    input wire        HOME_IN,
    input wire        STEP_OUT,
    input wire        DIR_CW,
    input wire [7:0]  CURRENT_PEAK,
    input wire        CURRENT_IDLE
);
    // ------------------------------
    // Bus and motion checks
    // ------------------------------
    default clocking @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);
    wire adr_bad = PADDR > 8'h24 || PADDR[1:0] != 2'h0;

    setup_ans_a: assert property (CE && PSEL && !PENABLE |=> PREADY)
        else $error("setup not answered in next cycle");
    pready_one_a: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    rd_hold_a: assert property (!PREADY |-> $stable(PRDATA))
        else $error("read data moved outside an answer");
    addr_err_a: assert property (PREADY && adr_bad |-> PSLVERR)
        else $error("bad address not refused");
    addr_ok_a: assert property (PREADY && !PWRITE && !adr_bad |-> !PSLVERR)
        else $error("good read refused");
    step_pulse_a: assert property (STEP_OUT |=> !STEP_OUT [*8])
        else $error("step pulse too long or too close");
    dir_hold_a: assert property (STEP_OUT |-> $stable(DIR_CW))
        else $error("direction changed with a step");
    idle_step_a: assert property (CURRENT_IDLE |-> !STEP_OUT)
        else $error("step issued while idle");

    cover property (STEP_OUT && !DIR_CW);
    cover property (PREADY && PSLVERR);
    cover property ($fell(CURRENT_IDLE));
endmodule

bind sefh_top sefh_chk #(.PW(PW)) u_chk (
    .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .ENC_A(ENC_A), .ENC_B(ENC_B), .ENC_Z(ENC_Z), .HOME_IN(HOME_IN), .STEP_OUT(STEP_OUT),
    .DIR_CW(DIR_CW), .CURRENT_PEAK(CURRENT_PEAK), .CURRENT_IDLE(CURRENT_IDLE));

//--- sefh_enc_model.sv
// Motor and shaft encoder model driven by the step outputs
`timescale 1ns/1ns
module sefh_enc_model (
    input  wire clk,
    input  wire rst,
    input  wire step,
    input  wire dir_cw,
    input  wire stall,
    output wire enc_a,
    output wire enc_b
);
    // ------------------------------
    // Shaft phase
    // ------------------------------
    reg [1:0] ph_r;
    // One step is one count, as steps per turn equal counts per turn
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ph_r <= 2'h0;
        end else if (step && !stall) begin
            ph_r <= dir_cw ? ph_r + 2'h1 : ph_r - 2'h1;
        end
    end
    // Gray sequence, B leads A when turning clockwise, so clockwise counts up
    assign enc_a = ph_r[1];
    assign enc_b = ph_r[1] ^ ph_r[0];
endmodule

//--- tb_top.sv
// Self-checking bench for the encoder feedback and homing block
`timescale 1ns/1ns
`include "sefh_defs.vh"
module tb_top;
    reg         CLK_SYS, RST, CE, PSEL, PENABLE, PWRITE, ENC_Z, HOME_IN, stall, e;
    reg  [7:0]  PADDR, run;
    reg  [31:0] PWDATA, q, p;
    reg  [6:0]  g, pct;
    wire [31:0] PRDATA;
    wire [7:0]  CURRENT_PEAK;
    wire        PREADY, PSLVERR, ENC_A, ENC_B, STEP_OUT, DIR_CW, CURRENT_IDLE;
    integer     num_errors, n_compared, seed, i, k, n;

    sefh_top #(.PW(24)) dut (
        .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .ENC_A(ENC_A), .ENC_B(ENC_B), .ENC_Z(ENC_Z), .HOME_IN(HOME_IN),
        .STEP_OUT(STEP_OUT), .DIR_CW(DIR_CW), .CURRENT_PEAK(CURRENT_PEAK),
        .CURRENT_IDLE(CURRENT_IDLE));
    sefh_enc_model u_enc (.clk(CLK_SYS), .rst(RST), .step(STEP_OUT), .dir_cw(DIR_CW),
        .stall(stall), .enc_a(ENC_A), .enc_b(ENC_B));

    // ------------------------------
    // Clock, helpers and bus tasks
    // ------------------------------
    initial begin
        CLK_SYS = 1'b0;
        forever #4 CLK_SYS = ~CLK_SYS;
    end
    // Index toggles every cycle so any correction by it would show
    always @(posedge CLK_SYS) ENC_Z <= ~ENC_Z;

    function [31:0] sx(input [23:0] v);
        sx = {{8{v[23]}}, v};
    endfunction
    function ferr(input [6:0] gv, input er);
        ferr = gv < `SEFH_GAIN_MIN || gv > `SEFH_GAIN_MAX || (er && gv > `SEFH_GAIN_EARLY);
    endfunction
    function [6:0] gtab(input integer j);
        case (j)
            0: gtab = 7'h00;
            1: gtab = 7'h01;
            2: gtab = 7'h05;
            3: gtab = 7'h28;
            4: gtab = 7'h29;
            5: gtab = 7'h50;
            default: gtab = 7'h51;
        endcase
    endfunction

    task results;
        if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task tmo;
        num_errors = num_errors + 1;
        results;
    endtask
    task cmp(input string nm, input [31:0] x, input [31:0] s);
        n_compared = n_compared + 1;
        if (s !== x) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %s expected %h seen %h", nm, x, s);
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        integer t;
        begin
            @(posedge CLK_SYS);
            PSEL <= 1'b1;
            PWRITE <= w;
            PADDR <= a;
            PWDATA <= d;
            @(posedge CLK_SYS);
            PENABLE <= 1'b1;
            t = 0;
            do begin
                @(posedge CLK_SYS);
                t = t + 1;
            end while (PREADY !== 1'b1 && t < 20);
            q = PRDATA;
            e = PSLVERR;
            PSEL <= 1'b0;
            PENABLE <= 1'b0;
            if (t >= 20) tmo;
        end
    endtask
    task wait_idle;
        begin
            n = 0;
            do begin
                apb(1'b0, `SEFH_A_STATUS, 32'h0);
                n = n + 1;
            end while (q[0] !== 1'b0 && n < 8000);
            if (n >= 8000) tmo;
        end
    endtask
    // Leaves in n the cycles between two step pulses
    task gap;
        begin
            n = 0;
            while (STEP_OUT !== 1'b1 && n < 5000) begin
                @(posedge CLK_SYS);
                n = n + 1;
            end
            n = 0;
            do begin
                @(posedge CLK_SYS);
                n = n + 1;
            end while (STEP_OUT !== 1'b1 && n < 5000);
            if (n >= 5000) tmo;
        end
    endtask

    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        seed = 42512;
        num_errors = 0;
        n_compared = 0;
        {RST, CE} = 2'h3;
        {PSEL, PENABLE, PWRITE, ENC_Z, HOME_IN, stall} = 6'h0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        repeat (4) @(posedge CLK_SYS);
        RST <= 1'b0;
        apb(1'b0, `SEFH_A_CFG, 32'h0);
        cmp("cfg_rst", `SEFH_RST_CFG, q);
        apb(1'b0, `SEFH_A_CPR, 32'h0);
        cmp("cpr_rst", {16'h0, `SEFH_RST_CPR}, q);
        apb(1'b0, 8'h28, 32'h0);
        cmp("unmapped", 32'h1, e);
        apb(1'b1, 8'h06, 32'h0);
        cmp("unaligned", 32'h1, e);
        for (i = 0; i < 4; i = i + 1) begin
            apb(1'b1, `SEFH_A_PRESET, sx(i[0] ? 24'h800000 : 24'h7FFFFF) ^ {{8{i[1]}}, 24'h0});
            cmp("preset_err", i[1], e);
        end
        // Absolute is refused before a motor-position preset, since that preset defines home
        apb(1'b1, `SEFH_A_CTRL, 32'h1);
        apb(1'b1, `SEFH_A_CMD, `SEFH_CMD_ABS);
        apb(1'b0, `SEFH_A_STATUS, 32'h0);
        cmp("abs_unhomed", 32'h1, q[5]);
        p = sx($random(seed));
        apb(1'b1, `SEFH_A_PRESET, p);
        apb(1'b1, `SEFH_A_CMD, `SEFH_CMD_PRE_M);
        apb(1'b1, `SEFH_A_CMD, `SEFH_CMD_PRE_E);
        apb(1'b0, `SEFH_A_MPOS, 32'h0);
        cmp("mpos_pre", p, q);
        apb(1'b0, `SEFH_A_EPOS, 32'h0);
        cmp("epos_pre", p, q);
        apb(1'b1, `SEFH_A_PRESET, 32'h6);
        apb(1'b1, `SEFH_A_CMD, `SEFH_CMD_REL);
        wait_idle;
        apb(1'b0, `SEFH_A_MPOS, 32'h0);
        cmp("mpos_rel", sx(p[23:0] + 24'h6), q);
        apb(1'b0, `SEFH_A_EPOS, 32'h0);
        cmp("epos_rel", sx(p[23:0] + 24'h6), q);
        for (k = 0; k < 2; k = k + 1) begin
            apb(1'b1, `SEFH_A_CMD, k ? `SEFH_CMD_HOME_N : `SEFH_CMD_HOME_P);
            gap;
            cmp("fast_gap", `SEFH_STEP_FAST + 16'h1, n);
            cmp("home_dir", k == 0, DIR_CW);
            HOME_IN <= 1'b1;
            repeat (4) @(posedge CLK_SYS);
            HOME_IN <= 1'b0;
            gap;
            gap;
            cmp("slow_gap", `SEFH_STEP_SLOW + 16'h1, n);
            HOME_IN <= 1'b1;
            wait_idle;
            HOME_IN <= 1'b0;
            cmp("homed", 32'h1, q[1]);
            apb(1'b0, `SEFH_A_MPOS, 32'h0);
            cmp("mpos_home", 32'h0, q);
            apb(1'b0, `SEFH_A_EPOS, 32'h0);
            cmp("epos_home", 32'h0, q);
        end
        apb(1'b1, `SEFH_A_PRESET, 32'h2);
        apb(1'b1, `SEFH_A_CMD, `SEFH_CMD_ABS);
        wait_idle;
        cmp("abs_homed", 32'h0, q[5]);
        apb(1'b0, `SEFH_A_MPOS, 32'h0);
        cmp("mpos_abs", 32'h2, q);
        // Shaft held: a 100-step move must end early on the lag trip
        stall <= 1'b1;
        apb(1'b1, `SEFH_A_CPR, 32'h10);
        apb(1'b1, `SEFH_A_CTRL, 32'h7);
        apb(1'b1, `SEFH_A_PRESET, 32'h64);
        apb(1'b1, `SEFH_A_CMD, `SEFH_CMD_REL);
        wait_idle;
        cmp("stall", 32'h1, q[2]);
        cmp("no_lag", 32'h0, q[3]);
        // Short turn so the full-turn lag is reached within a few slow steps
        apb(1'b1, `SEFH_A_CPR, 32'h4);
        apb(1'b1, `SEFH_A_CTRL, 32'h1);
        apb(1'b1, `SEFH_A_CMD, 32'h19);
        n = 0;
        do begin
            apb(1'b0, `SEFH_A_STATUS, 32'h0);
            n = n + 1;
        end while (q[3] !== 1'b1 && n < 3000);
        cmp("lag", 32'h1, q[3]);
        cmp("still_busy", 32'h1, q[0]);
        apb(1'b1, `SEFH_A_CMD, `SEFH_CMD_STOP);
        wait_idle;
        stall <= 1'b0;
        for (i = 0; i < 14; i = i + 1) begin
            g = gtab(i / 2);
            pct = (i % 4 == 3) ? 7'h64 : i[1:0] * 7'h19;
            p = $random(seed);
            run = {p[5:0], 2'h0};
            apb(1'b1, `SEFH_A_CTRL, {27'h0, i[0], 4'h0});
            apb(1'b1, `SEFH_A_CFG, {8'h05, run, 1'b0, g, 1'b0, pct});
            apb(1'b1, `SEFH_A_CMD, 32'h0);
            repeat (130) @(posedge CLK_SYS);
            apb(1'b0, `SEFH_A_STATUS, 32'h0);
            cmp("cfg_err", ferr(g, i[0]), q[4]);
            cmp("idle_peak", ({24'h0, run} * pct) / 100, CURRENT_PEAK);
            cmp("idle_flag", 32'h1, CURRENT_IDLE);
        end
        results;
    end
endmodule
